// ==== rtl/timer0_pkg.sv ====
// Summary of operation
// R1: one prescaler serves either watchdog or timer, never both; assign bit set means watchdog.
// R2: with prescaler on the watchdog, the timer counts every selected event 1:1.
// R3: with prescaler on the timer, the watchdog steps 1:1 on its own base divider.
// R4: rate field gives timer 1:2 to 1:256, watchdog 1:1 to 1:128.
// R5: option register is read/write and resets to all ones on every reset.
// R6: watchdog is held while a system clock switch is in progress.
// R7: after the switch completes the watchdog resumes from a cleared count.
// R8: start-up timing only runs when switching to the three crystal modes.
// R9: software clears watchdog and prescaler before moving prescaler to the timer; the bench writes 8'h80 and 8'h87 with no clear first.
// R10: source bit picks instruction clock or pin; edge bit one means falling edges.
// R11: pull-up disable bit turns pull-ups off; irq edge bit one means rising edge.
package timer0_pkg;

    localparam int CLK_PERIOD_NS    = 10;
    localparam int WDT_BASE_TIME_NS = 10000;
    localparam int WDT_BASE_CYCLES  = WDT_BASE_TIME_NS / CLK_PERIOD_NS;
    localparam int OST_CYCLES       = 1024;
    localparam int INSTR_DIV        = 4;

    localparam logic [7:0] IDX_TIMER0_COUNT      = 8'h01;
    localparam logic [7:0] IDX_INTERRUPT_CONTROL = 8'h0b;
    localparam logic [7:0] IDX_OPTION_CONTROL    = 8'h81;
    localparam logic [7:0] IDX_WATCHDOG_CONTROL  = 8'h90;
    localparam logic [7:0] IDX_CLOCK_SWITCH      = 8'h91;

    localparam logic [7:0] OPTION_RESET   = 8'hff;
    localparam logic [7:0] BYTE_ZERO      = 8'h00;
    localparam logic [7:0] WDC_RESET      = 8'h02;
    localparam int         INTC_TMR_FLAG  = 2;
    localparam int         INTC_EXT_FLAG  = 1;
    localparam int         WDC_CLEAR      = 0;
    localparam int         WDC_ENABLE     = 1;
    localparam int         WDC_TIMEOUT    = 2;
    localparam int         CSW_BUSY       = 3;

    localparam logic [2:0] MODE_LP    = 3'h0;
    localparam logic [2:0] MODE_XT    = 3'h1;
    localparam logic [2:0] MODE_HS    = 3'h2;
    localparam logic [2:0] MODE_INTRC = 3'h4;

    typedef struct packed {
        logic       pullup_disable;
        logic       irq_edge;
        logic       clock_source;
        logic       source_edge;
        logic       prescaler_assign;
        logic [2:0] prescale_rate;
    } option_t;

    typedef enum logic [2:0] {
        ST_RUN  = 3'b001,
        ST_OST  = 3'b010,
        ST_DONE = 3'b100
    } switch_state_t;

endpackage

// ==== rtl/prescale_counter.sv ====
`timescale 1ns/1ps
module prescale_counter #(
    parameter int WIDTH = 8
) (
    input  wire logic       clock_in,
    input  wire logic       sys_rst_in,
    input  wire logic       clear_in,
    input  wire logic       tick_in,
    input  wire logic [3:0] shift_in,
    output logic            pulse_out
);
    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] mask;

    // ratio 2^shift: pulse when the low shift bits roll over
    assign mask      = WIDTH'((1 << shift_in) - 1); // R4
    assign pulse_out = tick_in && ((count & mask) == mask);

    always_ff @(posedge clock_in) begin
        if (sys_rst_in || clear_in) begin
            count <= '0;
        end else if (tick_in) begin
            count <= count + WIDTH'(1);
        end
    end
endmodule

// ==== rtl/timer0_option_top.sv ====
`timescale 1ns/1ps
module timer0_option_top
#(
    parameter int BASE_CYCLES    = timer0_pkg::WDT_BASE_CYCLES,
    parameter int STARTUP_CYCLES = timer0_pkg::OST_CYCLES,
    parameter int WDT_BITS       = 8
) (
    input  wire logic        clock_in,
    input  wire logic        sys_rst_in,
    input  wire logic        wb_cyc_in,
    input  wire logic        wb_stb_in,
    input  wire logic        wb_we_in,
    input  wire logic [9:0]  wb_adr_in,
    input  wire logic [3:0]  wb_sel_in,
    input  wire logic [31:0] wb_dat_in,
    input  wire logic        counter_pin_in,
    input  wire logic        ext_irq_pin_in,
    output logic [31:0]      wb_dat_out,
    output logic             wb_ack_out,
    output logic             pullups_off_out,
    output logic             watchdog_timeout_out,
    output logic             clock_busy_out,
    output logic [2:0]       system_mode_out
);
    import timer0_pkg::*;
    default clocking check_cb @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);

    option_t          option;
    logic [7:0]       timer0_count;
    logic [7:0]       interrupt_control;
    logic             wdt_enable;
    logic             wdt_timeout;
    logic [2:0]       target_mode;
    switch_state_t    state;
    logic [15:0]      ripple;
    logic [WDT_BITS-1:0] wdt_count;
    logic [1:0]       instr_div;
    logic [2:0]       pin_sync;
    logic [2:0]       irq_sync;

    logic [7:0] index;
    logic [7:0] rd_byte;
    logic [3:0] presc_shift;
    logic       access, wr, tmr_wr, wdt_clear, sw_req;
    logic       instr_tick, pin_event, irq_event, timer_event;
    logic       wdt_base, presc_in, presc_pulse, presc_clear;
    logic       timer_inc, wdt_step, is_xtal, ost_done;

    assign index  = wb_adr_in[9:2];
    assign access = wb_cyc_in && wb_stb_in && !wb_ack_out;
    assign wr     = access && wb_we_in && wb_sel_in[0];
    assign tmr_wr = wr && (index == IDX_TIMER0_COUNT);
    assign wdt_clear = wr && (index == IDX_WATCHDOG_CONTROL)
                       && wb_dat_in[WDC_CLEAR];
    assign sw_req = wr && (index == IDX_CLOCK_SWITCH) && (state == ST_RUN);
    assign is_xtal = (wb_dat_in[2:0] == MODE_LP)
                     || (wb_dat_in[2:0] == MODE_XT)
                     || (wb_dat_in[2:0] == MODE_HS);

    // pins pass three flops; edges taken between the second and third
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            pin_sync <= '0;
            irq_sync <= '0;
        end else begin
            pin_sync <= {pin_sync[1:0], counter_pin_in};
            irq_sync <= {irq_sync[1:0], ext_irq_pin_in};
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            instr_div <= '0;
        end else begin
            instr_div <= instr_div + 2'(1);
        end
    end

    assign instr_tick = (instr_div == 2'(INSTR_DIV - 1));
    assign pin_event  = option.source_edge                       // R10
                        ? (pin_sync[2] && !pin_sync[1])
                        : (!pin_sync[2] && pin_sync[1]);
    assign irq_event  = option.irq_edge                          // R11
                        ? (!irq_sync[2] && irq_sync[1])
                        : (irq_sync[2] && !irq_sync[1]);
    assign timer_event = option.clock_source ? pin_event : instr_tick; // R10

    // shared prescaler sits on exactly one path
    assign presc_in    = option.prescaler_assign ? wdt_base : timer_event; // R1
    assign presc_shift = option.prescaler_assign                 // R4
                         ? {1'b0, option.prescale_rate}
                         : {1'b0, option.prescale_rate} + 4'(1);
    assign presc_clear = (wdt_clear && option.prescaler_assign)
                         || (tmr_wr && !option.prescaler_assign);
    assign timer_inc   = option.prescaler_assign ? timer_event  // R2
                                                 : presc_pulse;
    assign wdt_step    = option.prescaler_assign ? presc_pulse  // R3
                                                 : wdt_base;

    prescale_counter #(.WIDTH(8)) prescaler (
        .clock_in   (clock_in),
        .sys_rst_in (sys_rst_in),
        .clear_in   (presc_clear),
        .tick_in    (presc_in),
        .shift_in   (presc_shift),
        .pulse_out  (presc_pulse)
    );

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            option <= OPTION_RESET;                              // R5
        end else if (wr && index == IDX_OPTION_CONTROL) begin
            option <= wb_dat_in[7:0];                            // R5
        end
    end

    // a write to the count also restarts a timer-owned prescaler
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            timer0_count <= BYTE_ZERO;
        end else if (tmr_wr) begin
            timer0_count <= wb_dat_in[7:0];
        end else if (timer_inc) begin
            timer0_count <= timer0_count + 8'(1);
        end
    end

    // hardware set wins over a same-cycle software clear
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            interrupt_control <= BYTE_ZERO;
        end else begin
            if (wr && index == IDX_INTERRUPT_CONTROL) begin
                interrupt_control <= wb_dat_in[7:0];
            end
            if (timer_inc && !tmr_wr && timer0_count == 8'hff) begin
                interrupt_control[INTC_TMR_FLAG] <= 1'b1;
            end
            if (irq_event) begin
                interrupt_control[INTC_EXT_FLAG] <= 1'b1;
            end
        end
    end

    // ripple counter: watchdog base divider or start-up timer
    assign wdt_base = (state == ST_RUN) && (ripple == 16'(BASE_CYCLES - 1));
    assign ost_done = (ripple == 16'(STARTUP_CYCLES - 1));

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            ripple <= '0;
        end else if (sw_req || state == ST_DONE || wdt_clear || wdt_base) begin
            ripple <= '0;
        end else if (state == ST_RUN || state == ST_OST) begin
            ripple <= ripple + 16'(1);
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            state       <= ST_RUN;
            target_mode <= MODE_INTRC;
        end else begin
            case (state)
                ST_RUN: begin
                    if (sw_req) begin
                        target_mode <= wb_dat_in[2:0];
                        state <= is_xtal ? ST_OST : ST_DONE;     // R8
                    end
                end
                ST_OST: begin
                    if (ost_done) begin
                        state <= ST_DONE;
                    end
                end
                ST_DONE: state <= ST_RUN;
                default: state <= ST_RUN;
            endcase
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            system_mode_out <= MODE_INTRC;
            clock_busy_out  <= 1'b0;
        end else begin
            if (state == ST_DONE) begin
                system_mode_out <= target_mode;
            end
            clock_busy_out <= (state != ST_RUN) || sw_req;
        end
    end

    // count frozen during a switch, restarted from zero after it
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            wdt_count <= '0;
        end else if (wdt_clear || state == ST_DONE) begin
            wdt_count <= '0;                                     // R7
        end else if (state == ST_RUN && wdt_enable && wdt_step) begin
            wdt_count <= wdt_count + WDT_BITS'(1);               // R6
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            wdt_enable           <= WDC_RESET[WDC_ENABLE];
            wdt_timeout          <= 1'b0;
            watchdog_timeout_out <= 1'b0;
        end else begin
            watchdog_timeout_out <= state == ST_RUN && wdt_enable && wdt_step
                                    && (&wdt_count) && !wdt_clear;
            if (wr && index == IDX_WATCHDOG_CONTROL) begin
                wdt_enable  <= wb_dat_in[WDC_ENABLE];
                wdt_timeout <= wb_dat_in[WDC_TIMEOUT] ? 1'b0 : wdt_timeout;
            end
            if (watchdog_timeout_out) begin
                wdt_timeout <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            pullups_off_out <= OPTION_RESET[7];
        end else begin
            pullups_off_out <= option.pullup_disable;            // R11
        end
    end

    always_comb begin
        rd_byte = BYTE_ZERO;
        case (index)
            IDX_TIMER0_COUNT:      rd_byte = timer0_count;
            IDX_INTERRUPT_CONTROL: rd_byte = interrupt_control;
            IDX_OPTION_CONTROL:    rd_byte = option;
            IDX_WATCHDOG_CONTROL: begin
                rd_byte[WDC_ENABLE]  = wdt_enable;
                rd_byte[WDC_TIMEOUT] = wdt_timeout;
            end
            IDX_CLOCK_SWITCH: begin
                rd_byte[2:0]      = system_mode_out;
                rd_byte[CSW_BUSY] = state != ST_RUN;
            end
            default:               rd_byte = BYTE_ZERO;
        endcase
    end

    // unmapped indices still ack, reading zero
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            wb_ack_out <= 1'b0;
            wb_dat_out <= 32'h0000_0000;
        end else begin
            wb_ack_out <= access;
            wb_dat_out <= access ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end
    end

    AST_ONE_OWNER: assert property (presc_pulse // R1
        |-> (option.prescaler_assign ? wdt_base : timer_event))
        else $error("prescaler pulsed without a tick from its owner");
    AST_TIMER_UNDIV: assert property (option.prescaler_assign // R2
        && timer_event && !tmr_wr
        |=> timer0_count == $past(timer0_count) + 8'(1))
        else $error("timer not 1:1 with prescaler on watchdog");
    AST_WDT_OWN: assert property (!option.prescaler_assign // R3
        && state == ST_RUN && wdt_enable && wdt_base && !wdt_clear
        |=> wdt_count == $past(wdt_count) + WDT_BITS'(1))
        else $error("watchdog step not from own divider");
    AST_RATE: assert property (!option.prescaler_assign && timer_inc // R4
        |-> timer_event && prescaler.count[0])
        else $error("timer rate below 1:2");
    AST_OPT_RESET: assert property ($past(sys_rst_in) // R5
        |-> option == OPTION_RESET)
        else $error("option not all ones after reset");
    AST_SWITCH_HOLD: assert property (state == ST_OST && !wdt_clear // R6
        |=> $stable(wdt_count))
        else $error("watchdog moved during switch");
    AST_RESUME_CLEAR: assert property (state == ST_DONE // R7
        |=> wdt_count == '0 && state == ST_RUN)
        else $error("watchdog not cleared after switch");
    AST_OST_XTAL: assert property (sw_req // R8
        |=> state == ($past(is_xtal) ? ST_OST : ST_DONE))
        else $error("start-up timer used for wrong mode");
    AST_SRC_EDGE: assert property (option.clock_source // R10
        && !option.source_edge && !pin_sync[2] && pin_sync[1]
        |-> timer_event)
        else $error("rising pin edge not counted");
    AST_PULLUP: assert property (##1 pullups_off_out // R11
        == $past(option.pullup_disable))
        else $error("pull-up output does not follow option");

    COV_XTAL_SWITCH: cover property (@(posedge clock_in)
        state == ST_OST ##1 state == ST_DONE);
    COV_TIMER_WRAP: cover property (@(posedge clock_in)
        timer_inc && timer0_count == 8'hff);
    COV_WDT_TIMEOUT: cover property (@(posedge clock_in)
        watchdog_timeout_out);
endmodule

// ==== verification/timer0_prescaler_option_control_tb.sv ====
`timescale 1ns/1ps
module timer0_prescaler_option_control_tb;
    import timer0_pkg::*;
    localparam int BASE  = 8;
    localparam int START = 40;
    localparam int WBITS = 2;
    localparam int LIMIT = 30000;
    logic        clock_in;
    logic        sys_rst_in;
    logic        wb_cyc_in;
    logic        wb_stb_in;
    logic        wb_we_in;
    logic [9:0]  wb_adr_in;
    logic [3:0]  wb_sel_in;
    logic [31:0] wb_dat_in;
    logic        counter_pin_in;
    logic        ext_irq_pin_in;
    logic [31:0] wb_dat_out;
    logic        wb_ack_out;
    logic        pullups_off_out;
    logic        watchdog_timeout_out;
    logic        clock_busy_out;
    logic [2:0]  system_mode_out;
    int          miscompares = 0;
    int          n_checks    = 0;
    int          cycles      = 0;
    int          busy_cnt    = 0;
    int          wdt_in_busy = 0;
    int          g;
    int          w;
    logic [2:0]  modes [4];

    timer0_option_top #(.BASE_CYCLES(BASE), .STARTUP_CYCLES(START),
        .WDT_BITS(WBITS)) dut_u (
        .clock_in(clock_in), .sys_rst_in(sys_rst_in),
        .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
        .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
        .counter_pin_in(counter_pin_in), .ext_irq_pin_in(ext_irq_pin_in),
        .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
        .pullups_off_out(pullups_off_out),
        .watchdog_timeout_out(watchdog_timeout_out),
        .clock_busy_out(clock_busy_out), .system_mode_out(system_mode_out));

    initial begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end

    // hang guard and busy-window monitor
    always @(posedge clock_in) begin
        cycles <= cycles + 1;
        if (clock_busy_out === 1'b1) begin
            busy_cnt <= busy_cnt + 1;
            if (watchdog_timeout_out !== 1'b0) begin
                wdt_in_busy <= wdt_in_busy + 1;
            end
        end
        if (cycles >= LIMIT) begin
            miscompares = miscompares + 1;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic compare(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one classic cycle; waits on ack, never on a fixed latency
    task automatic wb_access(input logic [7:0] idx, input logic we,
                             input logic [7:0] wd, output logic [31:0] rdat);
        wb_cyc_in <= 1'b1;
        wb_stb_in <= 1'b1;
        wb_we_in  <= we;
        wb_adr_in <= {idx, 2'b00};
        wb_sel_in <= 4'h1;
        wb_dat_in <= 32'(wd);
        // only the bench-wide cycle ceiling ends this wait
        do begin
            @(posedge clock_in);
        end while (wb_ack_out !== 1'b1);
        rdat = wb_dat_out;
        wb_cyc_in <= 1'b0;
        wb_stb_in <= 1'b0;
        wb_we_in  <= 1'b0;
        @(posedge clock_in);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] x;
        wb_access(idx, 1'b1, d, x);
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        logic [31:0] x;
        wb_access(idx, 1'b0, 8'h00, x);
        compare(x, 32'(exp));
    endtask

    // held 6 cycles, beyond the 2-flop sync and edge detect
    task automatic pin_set(input logic v);
        counter_pin_in <= v;
        repeat (6) @(posedge clock_in);
    endtask

    task automatic irq_set(input logic v);
        ext_irq_pin_in <= v;
        repeat (6) @(posedge clock_in);
    endtask

    task automatic pulses(input int n);
        repeat (n) begin
            pin_set(1'b1);
            pin_set(1'b0);
        end
    endtask

    task automatic wait_to(input int t);
        while (cycles < t) @(posedge clock_in);
    endtask

    // two reads 64 cycles apart at the same phase: difference is exact
    task automatic rate_chk(input logic [7:0] opt, input logic [7:0] exp);
        logic [31:0] a;
        logic [31:0] b;
        int          t;
        wr(IDX_OPTION_CONTROL, opt);
        t = cycles + 4;
        wait_to(t);
        wb_access(IDX_TIMER0_COUNT, 1'b0, 8'h00, a);
        wait_to(t + 64);
        wb_access(IDX_TIMER0_COUNT, 1'b0, 8'h00, b);
        compare(32'(b[7:0] - a[7:0]), 32'(exp));
    endtask

    // first gap may straddle the option write, so the second is measured
    task automatic wdt_gap(output int gap);
        int t0;
        int n;
        t0 = 0;
        gap = 0;
        repeat (2) begin
            n = 0;
            do begin
                @(posedge clock_in);
                n++;
            end while (watchdog_timeout_out !== 1'b1 && n < 2000);
            gap = cycles - t0;
            t0 = cycles;
        end
    endtask

    initial begin
        modes = '{MODE_LP, MODE_XT, MODE_HS, MODE_INTRC};
        sys_rst_in = 1'b1;
        wb_cyc_in = 1'b0;
        wb_stb_in = 1'b0;
        wb_we_in = 1'b0;
        wb_adr_in = 10'h000;
        wb_sel_in = 4'h0;
        wb_dat_in = 32'h0000_0000;
        counter_pin_in = 1'b0;
        ext_irq_pin_in = 1'b0;
        repeat (5) @(posedge clock_in);
        sys_rst_in <= 1'b0;
        @(posedge clock_in);
        compare(32'(pullups_off_out), 32'h1);
        compare(32'(system_mode_out), 32'(MODE_INTRC));
        rd_chk(IDX_OPTION_CONTROL, OPTION_RESET);
        rd_chk(8'h10, BYTE_ZERO);
        wr(IDX_OPTION_CONTROL, 8'h5a);
        rd_chk(IDX_OPTION_CONTROL, 8'h5a);
        compare(32'(pullups_off_out), 32'h0);
        $display("test reset_and_access done");
        for (int e = 0; e < 2; e++) begin
            wr(IDX_OPTION_CONTROL, 8'ha8 | 8'(e << 4));
            wr(IDX_TIMER0_COUNT, 8'h00);
            pin_set(1'b1);
            rd_chk(IDX_TIMER0_COUNT, 8'(1 - e));
            pin_set(1'b0);
            rd_chk(IDX_TIMER0_COUNT, 8'h01);
        end
        compare(32'(pullups_off_out), 32'h1);
        wr(IDX_TIMER0_COUNT, 8'hff);
        wr(IDX_INTERRUPT_CONTROL, 8'h00);
        pulses(1);
        rd_chk(IDX_TIMER0_COUNT, 8'h00);
        rd_chk(IDX_INTERRUPT_CONTROL, 8'h04);
        $display("test pin_edges done");
        for (int r = 0; r < 8; r++) begin
            wr(IDX_WATCHDOG_CONTROL, 8'h03);
            wr(IDX_OPTION_CONTROL, 8'ha0 | 8'(r));
            wr(IDX_TIMER0_COUNT, 8'h00);
            pulses((2 << r) - 1);
            rd_chk(IDX_TIMER0_COUNT, 8'h00);
            pulses(1);
            rd_chk(IDX_TIMER0_COUNT, 8'h01);
        end
        $display("test timer_rates done");
        rate_chk(8'h88, 8'h10);
        rate_chk(8'h80, 8'h08);
        rate_chk(8'h81, 8'h04);
        $display("test instruction_clock done");
        for (int r = 0; r < 4; r++) begin
            wr(IDX_OPTION_CONTROL, 8'h88 | 8'(r));
            wdt_gap(g);
            compare(32'(g), 32'((BASE * (2 ** WBITS)) << r));
        end
        wr(IDX_OPTION_CONTROL, 8'h87);
        wdt_gap(g);
        compare(32'(g), 32'(BASE * (2 ** WBITS)));
        rd_chk(IDX_WATCHDOG_CONTROL, 8'h06);
        $display("test watchdog_rates done");
        foreach (modes[i]) begin
            busy_cnt = 0;
            wr(IDX_CLOCK_SWITCH, 8'(modes[i]));
            w = 0;
            while (clock_busy_out === 1'b1 && w < 200) begin
                @(posedge clock_in);
                w++;
            end
            w = 0;
            do begin
                @(posedge clock_in);
                w++;
            end while (watchdog_timeout_out !== 1'b1 && w < 200);
            compare(32'(busy_cnt >= START), 32'(i < 3));
            compare(32'(w >= 26 && w <= 34), 32'h1);
            compare(32'(system_mode_out), 32'(modes[i]));
            rd_chk(IDX_CLOCK_SWITCH, 8'(modes[i]));
        end
        compare(32'(wdt_in_busy), 32'h0);
        $display("test clock_switch done");
        wr(IDX_TIMER0_COUNT, 8'h00);
        for (int e = 0; e < 2; e++) begin
            wr(IDX_OPTION_CONTROL, 8'h87 | 8'(e << 6));
            irq_set(~e[0]);
            wr(IDX_INTERRUPT_CONTROL, 8'h00);
            irq_set(e[0]);
            rd_chk(IDX_INTERRUPT_CONTROL, 8'h02);
            wr(IDX_INTERRUPT_CONTROL, 8'h00);
            irq_set(~e[0]);
            rd_chk(IDX_INTERRUPT_CONTROL, 8'h00);
        end
        $display("test irq_edge done");
        complete_run();
    end
endmodule
